// >>> rtl/lcbx_params.svh
/*
 * Offsets, field positions, reset values and cycle counts of the logic,
 * compare and flow-control execution block.
 * Assumes it is included by its bare name wherever these constants are used.
 */
`ifndef LCBX_PARAMS_SVH
`define LCBX_PARAMS_SVH

// register byte offsets on the bus
`define LCBX_ADR_CTRL 8'h00
`define LCBX_ADR_PC 8'h04
`define LCBX_ADR_FLAGS 8'h08
`define LCBX_ADR_SP 8'h0c
// register file window: 0x80 + 4*index, selected by address bit 7
`define LCBX_ADR_RF_BIT 7
`define LCBX_CTRL_RUN 0

// status flag bit positions
`define LCBX_FLAG_C 0
`define LCBX_FLAG_Z 1
`define LCBX_FLAG_N 2
`define LCBX_FLAG_V 3
`define LCBX_FLAG_S 4
`define LCBX_FLAG_H 5

// reset values
`define LCBX_RST_PC 16'h0000
`define LCBX_RST_FLAGS 8'h00
`define LCBX_RST_REG 8'h00

// cycles per instruction class, and return-address stack depth
`define LCBX_CYC_JMP 2
`define LCBX_CYC_CALL 3
`define LCBX_CYC_BR_TAKEN 2
`define LCBX_STK_DEPTH 16

// opcode value / mask pairs
`define LCBX_OP_OR 16'h2800
`define LCBX_OP_EOR 16'h2400
`define LCBX_OP_AND 16'h2000
`define LCBX_OP_COMPARE_SKIP_EQUAL 16'h1000
`define LCBX_MSK_RR 16'hfc00
`define LCBX_OP_ORI 16'h6000
`define LCBX_OP_ANDI 16'h7000
`define LCBX_OP_CPI 16'h3000
`define LCBX_OP_RELATIVE_JUMP 16'hc000
`define LCBX_OP_RELATIVE_CALL 16'hd000
`define LCBX_MSK_IMM 16'hf000
`define LCBX_OP_COM 16'h9400
`define LCBX_MSK_COM 16'hfe0f
`define LCBX_OP_POINTER_JUMP 16'h9409
`define LCBX_OP_POINTER_CALL 16'h9509
`define LCBX_MSK_FULL 16'hffff
`define LCBX_OP_SKIP_REG_BIT_CLEAR 16'hfc00
`define LCBX_OP_SKIP_REG_BIT_SET 16'hfe00
`define LCBX_MSK_SBR 16'hfe08
`define LCBX_OP_SKIP_IO_BIT_CLEAR 16'h9900
`define LCBX_OP_SKIP_IO_BIT_SET 16'h9b00
`define LCBX_MSK_SBI 16'hff00
`define LCBX_OP_BRANCH_FLAG_SET 16'hf000
`define LCBX_OP_BRANCH_FLAG_CLEAR 16'hf400
`define LCBX_OP_LDST 16'h9000
`define LCBX_MSK_LDST 16'hfc0f
`define LCBX_OP_LONG 16'h940c
`define LCBX_MSK_LONG 16'hfe0c

`endif

// >>> rtl/lcbx_pkg.sv
/*
 * Types of the logic, compare and flow-control execution block.
 * Assumes lcbx_params.svh for the numeric constants.
 */
package lcbx_pkg;

  typedef enum logic [3:0] {
    ST_HALT = 4'h1,
    ST_EXEC = 4'h2,
    ST_WAIT = 4'h4,
    ST_SKIP = 4'h8
  } lcbx_state_t;

  typedef enum logic [4:0] {
    OP_NONE, OP_OR, OP_EOR, OP_AND, OP_ORI, OP_ANDI, OP_COM, OP_CPI, OP_COMPARE_SKIP_EQUAL,
    OP_POINTER_JUMP, OP_POINTER_CALL, OP_RELATIVE_JUMP, OP_RELATIVE_CALL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR
  } lcbx_op_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } lcbx_wb_req_t;

endpackage : lcbx_pkg

// >>> rtl/lcbx_core.sv
/*
 * Execution core for logical, compare, skip and flow-control instructions,
 * with a 32 x 8 working register file, status flags, program counter and a
 * return-address stack, and a classic Wishbone slave for control and debug.
 * Assumes program memory answers pm_data_i for pm_addr_o in the same cycle,
 * and io_space_i comes from logic on the same clock.
 */
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcbx_params.svh"

module lcbx_core import lcbx_pkg::*; (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire lcbx_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // program memory
  output logic [15:0] pm_addr_o,
  input wire logic [15:0] pm_data_i,
  // bit-addressable i/o registers, 32 x 8
  input wire logic [255:0] io_space_i,
  // status
  output logic halted_o
);

  function automatic logic match(input logic [15:0] ins, input logic [15:0] msk, input logic [15:0] val);
    match = (ins & msk) == val;
  endfunction : match

  function automatic logic [7:0] logic_flags(input logic [7:0] r, input logic [7:0] f);
    logic [7:0] o;
    o = f;
    o[`LCBX_FLAG_Z] = (r == 8'h00);
    o[`LCBX_FLAG_N] = r[7];
    o[`LCBX_FLAG_V] = 1'b0;
    o[`LCBX_FLAG_S] = r[7];
    logic_flags = o;
  endfunction : logic_flags

  function automatic logic [7:0] sub_flags(input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] o;
    r = a - b;
    o = f;
    o[`LCBX_FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    o[`LCBX_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    o[`LCBX_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[`LCBX_FLAG_N] = r[7];
    o[`LCBX_FLAG_Z] = (r == 8'h00);
    o[`LCBX_FLAG_S] = r[7] ^ o[`LCBX_FLAG_V];
    sub_flags = o;
  endfunction : sub_flags

  lcbx_state_t st_q, st_d;
  lcbx_op_t op;
  logic [7:0] rf_q [32];
  logic [15:0] stk_q [`LCBX_STK_DEPTH];
  logic [3:0] sp_q;
  logic [15:0] pc_q, pc_d;
  logic [7:0] status_flags_register_q, flags_d;
  logic [1:0] wait_q, wait_d;
  logic run_q, ack_q, halted_q;
  logic [31:0] dat_q, rd_val;
  logic wr_en, push, imm_form, two_word, execn;
  logic [4:0] d_idx;
  logic [7:0] op_a, op_b, wr_val, mask;
  logic [15:0] ins, zptr, pc_inc, br_tgt, rel_tgt;
  logic bus_req, bus_wr, halted_now;

  assign ins = pm_data_i;
  assign execn = (st_q == ST_EXEC) && run_q;
  assign halted_now = (st_q == ST_HALT);

  // opcode decode
  always_comb begin
    op = OP_NONE;
    if (match(ins, `LCBX_MSK_RR, `LCBX_OP_OR)) op = OP_OR;
    else if (match(ins, `LCBX_MSK_RR, `LCBX_OP_EOR)) op = OP_EOR;
    else if (match(ins, `LCBX_MSK_RR, `LCBX_OP_AND)) op = OP_AND;
    else if (match(ins, `LCBX_MSK_RR, `LCBX_OP_COMPARE_SKIP_EQUAL)) op = OP_COMPARE_SKIP_EQUAL;
    else if (match(ins, `LCBX_MSK_IMM, `LCBX_OP_ORI)) op = OP_ORI;
    else if (match(ins, `LCBX_MSK_IMM, `LCBX_OP_ANDI)) op = OP_ANDI;
    else if (match(ins, `LCBX_MSK_IMM, `LCBX_OP_CPI)) op = OP_CPI;
    else if (match(ins, `LCBX_MSK_IMM, `LCBX_OP_RELATIVE_JUMP)) op = OP_RELATIVE_JUMP;
    else if (match(ins, `LCBX_MSK_IMM, `LCBX_OP_RELATIVE_CALL)) op = OP_RELATIVE_CALL;
    else if (match(ins, `LCBX_MSK_COM, `LCBX_OP_COM)) op = OP_COM;
    else if (match(ins, `LCBX_MSK_FULL, `LCBX_OP_POINTER_JUMP)) op = OP_POINTER_JUMP;
    else if (match(ins, `LCBX_MSK_FULL, `LCBX_OP_POINTER_CALL)) op = OP_POINTER_CALL;
    else if (match(ins, `LCBX_MSK_SBR, `LCBX_OP_SKIP_REG_BIT_CLEAR)) op = OP_SKIP_REG_BIT_CLEAR;
    else if (match(ins, `LCBX_MSK_SBR, `LCBX_OP_SKIP_REG_BIT_SET)) op = OP_SKIP_REG_BIT_SET;
    else if (match(ins, `LCBX_MSK_SBI, `LCBX_OP_SKIP_IO_BIT_CLEAR)) op = OP_SKIP_IO_BIT_CLEAR;
    else if (match(ins, `LCBX_MSK_SBI, `LCBX_OP_SKIP_IO_BIT_SET)) op = OP_SKIP_IO_BIT_SET;
    else if (match(ins, `LCBX_MSK_RR, `LCBX_OP_BRANCH_FLAG_SET)) op = OP_BRANCH_FLAG_SET;
    else if (match(ins, `LCBX_MSK_RR, `LCBX_OP_BRANCH_FLAG_CLEAR)) op = OP_BRANCH_FLAG_CLEAR;
  end

  // operand fetch and targets
  assign imm_form = (op == OP_ORI) || (op == OP_ANDI) || (op == OP_CPI);
  assign d_idx = imm_form ? {1'b1, ins[7:4]} : ins[8:4];
  assign op_a = rf_q[d_idx];
  assign op_b = imm_form ? {ins[11:8], ins[3:0]} : rf_q[{ins[9], ins[3:0]}];
  assign zptr = {rf_q[31], rf_q[30]};
  assign pc_inc = pc_q + 16'h0001;
  assign br_tgt = pc_q + {{9{ins[9]}}, ins[9:3]} + 16'h0001;
  assign rel_tgt = pc_q + {{4{ins[11]}}, ins[11:0]} + 16'h0001;
  assign two_word = match(ins, `LCBX_MSK_LDST, `LCBX_OP_LDST) || match(ins, `LCBX_MSK_LONG, `LCBX_OP_LONG);
  // the word carries the complemented mask
  assign mask = 8'hff - op_b;

  // execute
  always_comb begin
    wr_en = 1'b0;
    wr_val = 8'h00;
    push = 1'b0;
    flags_d = status_flags_register_q;
    pc_d = pc_q;
    st_d = st_q;
    wait_d = wait_q;
    case (st_q)
      ST_HALT: begin
        if (run_q) st_d = ST_EXEC;
      end
      ST_EXEC: begin
        if (!run_q) begin
          st_d = ST_HALT;
        end else begin
          pc_d = pc_inc;
          case (op)
            OP_OR, OP_ORI: begin
              wr_en = 1'b1;
              wr_val = op_a | op_b;
              flags_d = logic_flags(op_a | op_b, status_flags_register_q);
            end
            OP_EOR: begin
              wr_en = 1'b1;
              wr_val = op_a ^ op_b;
              flags_d = logic_flags(op_a ^ op_b, status_flags_register_q);
            end
            OP_AND: begin
              wr_en = 1'b1;
              wr_val = op_a & op_b;
              flags_d = logic_flags(op_a & op_b, status_flags_register_q);
            end
            OP_ANDI: begin
              wr_en = 1'b1;
              wr_val = op_a & (8'hff - mask);
              flags_d = logic_flags(op_a & (8'hff - mask), status_flags_register_q);
            end
            OP_COM: begin
              wr_en = 1'b1;
              wr_val = 8'hff - op_a;
              flags_d = logic_flags(8'hff - op_a, status_flags_register_q);
              flags_d[`LCBX_FLAG_C] = 1'b1;
            end
            OP_CPI: flags_d = sub_flags(op_a, op_b, status_flags_register_q);
            OP_POINTER_JUMP, OP_RELATIVE_JUMP: begin
              pc_d = (op == OP_POINTER_JUMP) ? zptr : rel_tgt;
              st_d = ST_WAIT;
              wait_d = 2'(`LCBX_CYC_JMP - 1);
            end
            OP_POINTER_CALL, OP_RELATIVE_CALL: begin
              push = 1'b1;
              pc_d = (op == OP_POINTER_CALL) ? zptr : rel_tgt;
              st_d = ST_WAIT;
              wait_d = 2'(`LCBX_CYC_CALL - 1);
            end
            OP_COMPARE_SKIP_EQUAL: begin
              if (op_a == op_b) st_d = ST_SKIP;
            end
            OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET: begin
              if (op_a[ins[2:0]] == (op == OP_SKIP_REG_BIT_SET)) st_d = ST_SKIP;
            end
            OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
              if (io_space_i[ins[7:0]] == (op == OP_SKIP_IO_BIT_SET)) st_d = ST_SKIP;
            end
            OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR: begin
              // s=1 equal/not equal, s=0 carry, s=2 minus
              if (status_flags_register_q[ins[2:0]] == (op == OP_BRANCH_FLAG_SET)) begin
                pc_d = br_tgt;
                st_d = ST_WAIT;
                wait_d = 2'(`LCBX_CYC_BR_TAKEN - 1);
              end
            end
            default: ;
          endcase
        end
      end
      ST_WAIT: begin
        wait_d = wait_q - 2'h1;
        if (wait_q == 2'h1) st_d = ST_EXEC;
      end
      ST_SKIP: begin
        if (two_word) begin
          pc_d = pc_q + 16'h0002;
          st_d = ST_WAIT;
          wait_d = 2'h1;
        end else begin
          pc_d = pc_inc;
          st_d = ST_EXEC;
        end
      end
      default: st_d = ST_HALT;
    endcase
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_HALT;
      wait_q <= 2'h0;
      halted_q <= 1'b1;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      halted_q <= (st_d == ST_HALT);
    end
  end

  // program counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= `LCBX_RST_PC;
    end else if (bus_wr && halted_now && wb_req_i.adr == `LCBX_ADR_PC) begin
      if (wb_req_i.sel[0]) pc_q[7:0] <= wb_req_i.dat[7:0];
      if (wb_req_i.sel[1]) pc_q[15:8] <= wb_req_i.dat[15:8];
    end else begin
      pc_q <= pc_d;
    end
  end

  // status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_flags_register_q <= `LCBX_RST_FLAGS;
    end else if (bus_wr && halted_now && wb_req_i.adr == `LCBX_ADR_FLAGS && wb_req_i.sel[0]) begin
      status_flags_register_q <= wb_req_i.dat[7:0];
    end else begin
      status_flags_register_q <= flags_d;
    end
  end

  // working registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) rf_q[i] <= `LCBX_RST_REG;
    end else if (wr_en) begin
      rf_q[d_idx] <= wr_val;
    end else if (bus_wr && halted_now && wb_req_i.adr[`LCBX_ADR_RF_BIT] && wb_req_i.sel[0]) begin
      rf_q[wb_req_i.adr[6:2]] <= wb_req_i.dat[7:0];
    end
  end

  // return-address stack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_q <= 4'h0;
      for (int i = 0; i < `LCBX_STK_DEPTH; i++) stk_q[i] <= 16'h0000;
    end else if (push) begin
      stk_q[sp_q] <= pc_inc;
      sp_q <= sp_q + 4'h1;
    end
  end

  // wishbone slave
  assign bus_req = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign bus_wr = bus_req && wb_req_i.we;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (wb_req_i.adr[`LCBX_ADR_RF_BIT]) begin
      rd_val = {24'h00_0000, rf_q[wb_req_i.adr[6:2]]};
    end else begin
      case (wb_req_i.adr)
        `LCBX_ADR_CTRL: rd_val = {31'h0000_0000, run_q};
        `LCBX_ADR_PC: rd_val = {16'h0000, pc_q};
        `LCBX_ADR_FLAGS: rd_val = {24'h00_0000, status_flags_register_q};
        `LCBX_ADR_SP: rd_val = {28'h000_0000, sp_q};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_req_i.we) dat_q <= rd_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (bus_wr && wb_req_i.adr == `LCBX_ADR_CTRL && wb_req_i.sel[0]) begin
      run_q <= wb_req_i.dat[`LCBX_CTRL_RUN];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pm_addr_o = pc_q;
  assign halted_o = halted_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tail1;
    (st_q == ST_WAIT) ##1 (st_q == ST_EXEC);
  endsequence
  sequence s_tail2;
    (st_q == ST_WAIT) [*2] ##1 (st_q == ST_EXEC);
  endsequence

  chk_or_result: assert property (
    execn && (op == OP_OR) |=> rf_q[$past(d_idx)] == ($past(op_a) | $past(op_b)) && !status_flags_register_q[`LCBX_FLAG_V]
  ) else $error("or result or flags wrong");
  chk_xor_result: assert property (
    execn && (op == OP_EOR) |=> rf_q[$past(d_idx)] == ($past(op_a) ^ $past(op_b))
      && status_flags_register_q[`LCBX_FLAG_Z] == ($past(op_a) == $past(op_b))
  ) else $error("xor result or zero flag wrong");
  chk_invert_value: assert property (
    execn && (op == OP_COM) |=> rf_q[$past(d_idx)] == ~$past(op_a) && status_flags_register_q[`LCBX_FLAG_C]
  ) else $error("invert result or carry wrong");
  chk_set_mask: assert property (
    execn && (op == OP_ORI) |=> (rf_q[$past(d_idx)] & $past(op_b)) == $past(op_b)
      && status_flags_register_q[`LCBX_FLAG_N] == rf_q[$past(d_idx)][7]
  ) else $error("mask bits not set");
  chk_clear_mask: assert property (
    execn && (op == OP_ANDI) |=> (rf_q[$past(d_idx)] & $past(mask)) == 8'h00
      && (rf_q[$past(d_idx)] | $past(mask)) == ($past(op_a) | $past(mask))
  ) else $error("mask bits not cleared");
  chk_test_keeps: assert property (
    execn && (op == OP_AND) && (d_idx == {ins[9], ins[3:0]}) |=> rf_q[$past(d_idx)] == $past(op_a)
      && status_flags_register_q[`LCBX_FLAG_Z] == ($past(op_a) == 8'h00)
  ) else $error("test changed register or zero flag wrong");
  chk_ptr_jump: assert property (
    execn && (op == OP_POINTER_JUMP) |=> (pc_q == $past(zptr) && $stable(status_flags_register_q)) ##0 s_tail1
  ) else $error("pointer jump target or timing wrong");
  chk_ptr_call: assert property (
    execn && (op == OP_POINTER_CALL) |=> (pc_q == $past(zptr) && stk_q[$past(sp_q)] == $past(pc_inc)) ##0 s_tail2
  ) else $error("pointer call target, stack or timing wrong");
  chk_skip_equal: assert property (
    execn && (op == OP_COMPARE_SKIP_EQUAL) |=> (st_q == ST_SKIP) == $past(op_a == op_b) && $stable(status_flags_register_q)
  ) else $error("compare skip decision wrong");
  chk_cmp_imm: assert property (
    execn && (op == OP_CPI) |=> status_flags_register_q[`LCBX_FLAG_C] == ($past(op_a) < $past(op_b))
      && status_flags_register_q[`LCBX_FLAG_Z] == ($past(op_a) == $past(op_b)) && rf_q[$past(d_idx)] == $past(op_a)
  ) else $error("compare immediate flags wrong");
  chk_reg_skip: assert property (
    execn && (op == OP_SKIP_REG_BIT_CLEAR) && !op_a[ins[2:0]] |=> st_q == ST_SKIP ##1 st_q != ST_SKIP
  ) else $error("register bit skip missed");
  chk_io_skip: assert property (
    execn && (op == OP_SKIP_IO_BIT_SET) |=> (st_q == ST_SKIP) == $past(io_space_i[ins[7:0]])
  ) else $error("io bit skip decision wrong");
  chk_br_taken: assert property (
    execn && (op == OP_BRANCH_FLAG_SET) && status_flags_register_q[ins[2:0]] |=> (pc_q == $past(br_tgt)) ##0 s_tail1
  ) else $error("taken branch target or timing wrong");
  chk_br_fallthru: assert property (
    execn && (op == OP_BRANCH_FLAG_CLEAR) && status_flags_register_q[ins[2:0]] |=> pc_q == $past(pc_inc) && st_q != ST_WAIT && $stable(status_flags_register_q)
  ) else $error("untaken branch not sequential");
  chk_skip_length: assert property (
    (st_q == ST_SKIP) && two_word |=> (pc_q == $past(pc_q) + 16'h0002) ##0 s_tail1
  ) else $error("two-word skip length wrong");

endmodule : lcbx_core

`default_nettype wire

// >>> verif/lcbx_pmem.sv
/*
 * Program memory model: 64 words, read combinationally at the word address.
 * Assumes the bench fills mem before the core runs; unused words hold no-op 0000.
 */
`timescale 1ns/1ps
`default_nettype none

module lcbx_pmem (
  // fetch port
  input wire logic [15:0] addr_i,
  output logic [15:0] data_o
);
  logic [15:0] mem [0:63];

  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
  end

  // beyond the array the lines show a changing pattern, never a stale word
  assign data_o = (addr_i < 16'h0040) ? mem[addr_i[5:0]] : ~addr_i;
endmodule : lcbx_pmem

`default_nettype wire

// >>> verif/test_logic_compare_branch_exec.sv
/*
 * Self-checking bench: loads registers over Wishbone, runs a fixed program
 * and compares the per-cycle fetch trace and the final registers.
 * Assumes lcbx_core, lcbx_pkg and lcbx_params.svh from rtl/.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcbx_params.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_logic_compare_branch_exec import lcbx_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  lcbx_wb_req_t req = '0;
  logic [255:0] io_q = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] pm_addr_o;
  logic [15:0] pm_data_i;
  logic halted_o;
  int num_errors = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  logic [31:0] seed = 32'h3544e618;
  logic [31:0] exp_rd[$];
  logic [31:0] exp_pc[$];
  logic [31:0] e_rd;
  logic [31:0] e_pc;
  logic [7:0] v [16:31];
  logic [7:0] x [16:31];
  logic [7:0] k1, k2, k3;
  int trace [36] = '{0, 1, 2, 3, 4, 5, 6, 8, 8, 9, 10, 11, 12, 14, 14, 15, 16, 17, 18, 19,
                     30, 30, 31, 24, 24, 40, 40, 40, 41, 42, 42, 43, 44, 46, 46, 46};

  lcbx_core lcbx_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .io_space_i(io_q),
    .halted_o(halted_o));
  lcbx_pmem lcbx_pmem_i (.addr_i(pm_addr_o), .data_o(pm_data_i));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [15:0] rr(input logic [15:0] op, input int d, input int r);
    return op | ((16'(r) & 16'h0010) << 5) | (16'(d) << 4) | (16'(r) & 16'h000f);
  endfunction : rr

  function automatic logic [15:0] im(input logic [15:0] op, input int d, input logic [7:0] k);
    return op | (16'(k[7:4]) << 8) | (16'(d - 16) << 4) | 16'(k[3:0]);
  endfunction : im

  function automatic logic [15:0] br(input logic [15:0] op, input int s, input int k);
    return op | ((16'(k) & 16'h007f) << 3) | 16'(s);
  endfunction : br

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    req <= '0;
  endtask : wb_xfer

  task automatic wb_read(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb_xfer(a, 1'b0, 32'h0);
  endtask : wb_read

  // read data is judged at the edge where ack is seen
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && req.cyc && !req.we && exp_rd.size() > 0) begin
      e_rd = exp_rd.pop_front();
      `CHK(wb_dat_o, e_rd)
    end
  end

  // one fetch address per running cycle
  always @(posedge clk_i) begin
    if (halted_o === 1'b0 && exp_pc.size() > 0) begin
      e_pc = exp_pc.pop_front();
      `CHK({16'h0, pm_addr_o}, e_pc)
    end
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK({31'h0, halted_o}, 32'h1)
    wb_read(8'h00, 32'h0);
    wb_read(8'h04, 32'h0);
    wb_read(8'h08, 32'h0);
    wb_read(8'h0c, 32'h0);
    wb_read(8'h40, 32'h0);
    $display("test reset and map done");
    for (int i = 16; i < 32; i++) v[i] = rnd();
    k1 = rnd();
    k2 = rnd();
    k3 = rnd();
    v[22] = 8'h00;
    v[25] = v[24];
    v[26] = v[26] | 8'h01;
    v[27] = k3;
    v[28] = 8'h00;
    v[30] = 8'h28;
    v[31] = 8'h00;
    x = v;
    x[16] = v[16] | v[17];
    x[18] = v[18] ^ v[17];
    x[19] = v[19] | k1;
    x[20] = v[20] & ~k2;
    x[21] = ~v[21];
    x[28] = 8'hff;
    x[30] = 8'h2a;
    io_q <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()} & ~(256'h1 << 29);
    lcbx_pmem_i.mem[0] = rr(`LCBX_OP_OR, 16, 17);
    lcbx_pmem_i.mem[1] = rr(`LCBX_OP_EOR, 18, 17);
    lcbx_pmem_i.mem[2] = im(`LCBX_OP_ORI, 19, k1);
    lcbx_pmem_i.mem[3] = im(`LCBX_OP_ANDI, 20, ~k2);
    lcbx_pmem_i.mem[4] = `LCBX_OP_COM | (16'd21 << 4);
    lcbx_pmem_i.mem[5] = rr(`LCBX_OP_AND, 22, 22);
    lcbx_pmem_i.mem[6] = br(`LCBX_OP_BRANCH_FLAG_SET, 1, 1);
    lcbx_pmem_i.mem[7] = `LCBX_OP_COM | (16'd23 << 4);
    lcbx_pmem_i.mem[8] = br(`LCBX_OP_BRANCH_FLAG_CLEAR, 1, 5);
    lcbx_pmem_i.mem[9] = rr(`LCBX_OP_COMPARE_SKIP_EQUAL, 24, 25);
    lcbx_pmem_i.mem[10] = `LCBX_OP_COM | (16'd23 << 4);
    lcbx_pmem_i.mem[11] = `LCBX_OP_SKIP_REG_BIT_SET | (16'd26 << 4);
    lcbx_pmem_i.mem[12] = `LCBX_OP_LDST | (16'd23 << 4);
    lcbx_pmem_i.mem[13] = 16'h0100;
    lcbx_pmem_i.mem[14] = `LCBX_OP_SKIP_IO_BIT_CLEAR | 16'h001d;
    lcbx_pmem_i.mem[15] = `LCBX_OP_COM | (16'd23 << 4);
    lcbx_pmem_i.mem[16] = `LCBX_OP_SKIP_IO_BIT_SET | 16'h001d;
    lcbx_pmem_i.mem[17] = im(`LCBX_OP_CPI, 27, k3);
    lcbx_pmem_i.mem[18] = br(`LCBX_OP_BRANCH_FLAG_SET, 0, 3);
    lcbx_pmem_i.mem[19] = br(`LCBX_OP_BRANCH_FLAG_CLEAR, 0, 10);
    lcbx_pmem_i.mem[30] = `LCBX_OP_COM | (16'd28 << 4);
    lcbx_pmem_i.mem[31] = br(`LCBX_OP_BRANCH_FLAG_SET, 2, -8);
    lcbx_pmem_i.mem[24] = `LCBX_OP_POINTER_CALL;
    lcbx_pmem_i.mem[40] = im(`LCBX_OP_ORI, 30, 8'h02);
    lcbx_pmem_i.mem[41] = `LCBX_OP_POINTER_JUMP;
    lcbx_pmem_i.mem[42] = `LCBX_OP_SKIP_REG_BIT_CLEAR | (16'd22 << 4);
    lcbx_pmem_i.mem[43] = `LCBX_OP_COM | (16'd23 << 4);
    lcbx_pmem_i.mem[44] = `LCBX_OP_RELATIVE_CALL | 16'h0001;
    lcbx_pmem_i.mem[46] = `LCBX_OP_RELATIVE_JUMP | 16'h0fff;
    for (int i = 16; i < 32; i++) wb_xfer(8'h80 + 8'(4 * i), 1'b1, {24'h0, v[i]});
    wb_xfer(8'h0c, 1'b1, 32'h5);
    wb_read(8'h0c, 32'h0);
    for (int i = 0; i < 36; i++) exp_pc.push_back(32'(trace[i]));
    wb_xfer(8'h00, 1'b1, 32'h1);
    while (exp_pc.size() > 0) @(posedge clk_i);
    wb_xfer(8'h80 + 8'(4 * 23), 1'b1, 32'h55);
    wb_xfer(8'h00, 1'b1, 32'h0);
    while (halted_o !== 1'b1) @(posedge clk_i);
    $display("test program run done");
    for (int i = 16; i < 32; i++) wb_read(8'h80 + 8'(4 * i), {24'h0, x[i]});
    wb_read(8'h08, 32'h1);
    wb_read(8'h04, 32'd46);
    wb_read(8'h0c, 32'h2);
    @(posedge clk_i);
    $display("test final state done");
    results();
  end
endmodule : test_logic_compare_branch_exec

`default_nettype wire
